// ### design/smc_pkg.sv
// Constants, register map and types of the standby mode controller.
// Assumes one 20 MHz clock; wake sources from logic are on that clock.
package smc_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int OSC_WAIT_US = 200;
  localparam int OSC_WAIT_CYC = (OSC_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] OSC_WAIT_LOAD = 16'(OSC_WAIT_CYC - 1);
  localparam logic [15:0] SUB_WAIT_LOAD = 16'h000b;
  // Register indices; byte address is four times the index
  localparam logic [29:0] PROTECT_IDX = 30'h0ffff1fc;
  localparam logic [29:0] KIND_IDX = 30'h0ffff1fd;
  localparam logic [29:0] PSC_IDX = 30'h0ffff1fe;
  localparam logic [29:0] CLOCK_IDX = 30'h0ffff1ff;
  localparam logic [29:0] STATUS_IDX = 30'h0ffff200;
  localparam logic [7:0] PROTECT_KEY = 8'ha5;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam logic [7:0] PSC_MASK = 8'h72;
  localparam logic [7:0] KIND_RESET = 8'h00;
  localparam logic [7:0] KIND_MASK = 8'h03;
  localparam logic [7:0] CLOCK_RESET = 8'h08;
  localparam logic [7:0] CLOCK_MASK = 8'h0f;
  localparam int STP_BIT = 1;
  localparam int INT_DIS_BIT = 4;
  localparam int PIN_DIS_BIT = 5;
  localparam int WDT_DIS_BIT = 6;
  localparam int CC_SUB_RUN = 0;
  localparam int CC_LV_SUB = 1;
  localparam int CC_LV_STOP = 2;
  localparam int CC_PLL_RUN = 3;
  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_SUB = 2'h1;
  localparam logic [1:0] SRC_INT = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [8:0] {
    ST_NORMAL = 9'h001, ST_HALT = 9'h002, ST_LIGHT_IDLE_STATE = 9'h004, ST_DEEP_IDLE_STATE = 9'h008, ST_STOP = 9'h010,
    ST_SUB = 9'h020, ST_SUBIDLE = 9'h040, ST_OSCWAIT = 9'h080, ST_SUBWAIT = 9'h100
  } smc_mode_type;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic main_osc_en;
    logic pll_en;
    logic flash_en;
    logic sub_osc_en;
    logic low_voltage;
    logic [1:0] sys_clk_sel;
  } smc_clk_type;

  typedef struct packed {
    smc_mode_type mode;
    logic [7:0] power_save_control;
    logic [7:0] standby_kind_select;
    logic [7:0] clock_control;
    logic protect_armed;
    logic int_defer;
    logic use_internal;
    logic [15:0] wait_cnt;
    logic nmi_prev;
    logic sub_prev;
    smc_clk_type clk_out;
    logic awready;
    logic aw_have;
    logic [31:0] aw_addr;
    logic wready;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } smc_state_type;
endpackage : smc_pkg

// ### design/smc_sync3.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/10ps
module smc_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } smc_sync_state_type;

  smc_sync_state_type q;
  smc_sync_state_type n;

  always_comb begin
    n = q;
    n.s1 = din;
    n.s2 = q.s1;
    n.s3 = q.s2;
    // Change counts only once stages two and three agree
    n.level = (q.s2 & ~(q.s2 ^ q.s3)) | (q.level & (q.s2 ^ q.s3));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign dout = q.level;
endmodule : smc_sync3

// ### design/smc_standby_ctrl.sv
// Standby mode controller: mode sequencer, clock gating controls and registers.
// Assumes an AXI4-Lite master, CPU strobes and wake sources on clk; pins asynchronous.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module smc_standby_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU core
  input wire logic halt_req,
  input wire logic instr_done,
  output logic cpu_int_defer,
  // Wake sources
  input wire logic watchdog_overflow_signal,
  input wire logic maskable_irq,
  input wire logic nmi_pin,
  // Clock generator
  input wire logic subclk_pin,
  output smc_pkg::smc_clk_type clk_ctrl
);
  smc_pkg::smc_state_type q;
  smc_pkg::smc_state_type n;
  logic [1:0] pin_level;
  logic nmi_edge;
  logic sub_rise;
  logic wake;
  logic any_req;
  logic standby_request_bit;
  logic wr_fire;
  logic psc_attempt;
  logic [29:0] wr_idx;
  logic [29:0] rd_idx;
  logic [7:0] wbyte;

  smc_sync3 #(
    .W(2)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din({subclk_pin, nmi_pin}),
    .dout(pin_level)
  );

  assign nmi_edge = pin_level[0] & ~q.nmi_prev;
  assign sub_rise = pin_level[1] & ~q.sub_prev;
  assign standby_request_bit = q.power_save_control[smc_pkg::STP_BIT];
  assign wr_fire = q.aw_have & q.w_have & ~q.bvalid;
  assign wr_idx = q.aw_addr[31:2];
  assign rd_idx = s_axi_araddr[31:2];
  assign wbyte = q.wdata[7:0];
  assign psc_attempt = wr_fire & (wr_idx == smc_pkg::PSC_IDX) & (q.aw_addr[1:0] == 2'h0);
  // Any request releases the CPU pause regardless of disable bits
  assign any_req = watchdog_overflow_signal | nmi_edge | maskable_irq;
  assign wake = (watchdog_overflow_signal & ~q.power_save_control[smc_pkg::WDT_DIS_BIT])
    | (nmi_edge & ~q.power_save_control[smc_pkg::PIN_DIS_BIT])
    | (maskable_irq & ~q.power_save_control[smc_pkg::INT_DIS_BIT]);

  always_comb begin
    n = q;
    n.nmi_prev = pin_level[0];
    n.sub_prev = pin_level[1];
    // Write channel capture, either order
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // Interrupt deferral; a new power save control write wins over the instruction end
    if (instr_done) begin
      n.int_defer = 1'b0;
    end
    if (psc_attempt) begin
      n.int_defer = 1'b1;
    end
    if (wr_fire) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = smc_pkg::RESP_OKAY;
      // Arming lasts for exactly the next write
      n.protect_armed = 1'b0;
      if (q.aw_addr[1:0] != 2'h0) begin
        n.bresp = smc_pkg::RESP_SLVERR;
      end else begin
        case (wr_idx)
          smc_pkg::PROTECT_IDX: begin
            n.protect_armed = q.wstrb[0] && (wbyte == smc_pkg::PROTECT_KEY);
          end
          smc_pkg::PSC_IDX: begin
            if (q.protect_armed && q.wstrb[0]) begin
              n.power_save_control = wbyte & smc_pkg::PSC_MASK;
              if (wbyte[smc_pkg::STP_BIT]) begin
                // Disable bits keep their old values
                n.power_save_control[smc_pkg::WDT_DIS_BIT] = q.power_save_control[smc_pkg::WDT_DIS_BIT];
                n.power_save_control[smc_pkg::PIN_DIS_BIT] = q.power_save_control[smc_pkg::PIN_DIS_BIT];
                n.power_save_control[smc_pkg::INT_DIS_BIT] = q.power_save_control[smc_pkg::INT_DIS_BIT];
              end
            end
          end
          smc_pkg::KIND_IDX: begin
            if (q.wstrb[0]) begin
              n.standby_kind_select = wbyte & smc_pkg::KIND_MASK;
            end
          end
          smc_pkg::CLOCK_IDX: begin
            if (q.wstrb[0]) begin
              n.clock_control = wbyte & smc_pkg::CLOCK_MASK;
              n.use_internal = 1'b0;
            end
          end
          smc_pkg::STATUS_IDX: begin
            n.bresp = smc_pkg::RESP_OKAY;
          end
          default: begin
            n.bresp = smc_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    // Read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp = smc_pkg::RESP_OKAY;
      n.rdata = 32'h0000_0000;
      if (s_axi_araddr[1:0] != 2'h0) begin
        n.rresp = smc_pkg::RESP_SLVERR;
      end else begin
        case (rd_idx)
          smc_pkg::PROTECT_IDX: n.rdata = 32'h0000_0000;
          smc_pkg::PSC_IDX: n.rdata = {24'h000000, q.power_save_control};
          smc_pkg::KIND_IDX: n.rdata = {24'h000000, q.standby_kind_select};
          smc_pkg::CLOCK_IDX: n.rdata = {24'h000000, q.clock_control};
          smc_pkg::STATUS_IDX: begin
            n.rdata = {17'h00000, q.protect_armed, q.use_internal, q.int_defer, 3'h0, q.mode};
          end
          default: n.rresp = smc_pkg::RESP_SLVERR;
        endcase
      end
    end
    // Mode sequencer
    case (q.mode)
      smc_pkg::ST_NORMAL, smc_pkg::ST_SUB: begin
        if (halt_req) begin
          n.mode = smc_pkg::ST_HALT;
        end else if (standby_request_bit) begin
          if (q.standby_kind_select[0]) begin
            n.mode = smc_pkg::ST_STOP;
          end else if (q.mode == smc_pkg::ST_SUB) begin
            n.mode = smc_pkg::ST_SUBIDLE;
          end else if (q.standby_kind_select[1]) begin
            n.mode = smc_pkg::ST_DEEP_IDLE_STATE;
          end else begin
            n.mode = smc_pkg::ST_LIGHT_IDLE_STATE;
          end
        end else if (q.clock_control[smc_pkg::CC_SUB_RUN]) begin
          n.mode = smc_pkg::ST_SUB;
        end else begin
          n.mode = smc_pkg::ST_NORMAL;
        end
      end
      smc_pkg::ST_HALT: begin
        if (any_req) begin
          n.mode = q.clock_control[smc_pkg::CC_SUB_RUN] ? smc_pkg::ST_SUB : smc_pkg::ST_NORMAL;
        end
      end
      smc_pkg::ST_LIGHT_IDLE_STATE: begin
        if (wake) begin
          n.mode = smc_pkg::ST_NORMAL;
          n.power_save_control[smc_pkg::STP_BIT] = 1'b0;
        end
      end
      smc_pkg::ST_DEEP_IDLE_STATE, smc_pkg::ST_STOP: begin
        if (wake) begin
          n.mode = smc_pkg::ST_OSCWAIT;
          n.wait_cnt = smc_pkg::OSC_WAIT_LOAD;
          n.power_save_control[smc_pkg::STP_BIT] = 1'b0;
        end
      end
      smc_pkg::ST_SUBIDLE: begin
        if (wake) begin
          n.mode = smc_pkg::ST_SUBWAIT;
          n.wait_cnt = smc_pkg::SUB_WAIT_LOAD;
          n.power_save_control[smc_pkg::STP_BIT] = 1'b0;
        end
      end
      smc_pkg::ST_OSCWAIT: begin
        if (watchdog_overflow_signal) begin
          n.mode = smc_pkg::ST_NORMAL;
          n.use_internal = 1'b1;
        end else if (q.wait_cnt == 16'h0000) begin
          n.mode = q.clock_control[smc_pkg::CC_SUB_RUN] ? smc_pkg::ST_SUB : smc_pkg::ST_NORMAL;
        end else begin
          n.wait_cnt = q.wait_cnt - 16'h0001;
        end
      end
      smc_pkg::ST_SUBWAIT: begin
        if (sub_rise) begin
          if (q.wait_cnt == 16'h0000) begin
            n.mode = smc_pkg::ST_SUB;
          end else begin
            n.wait_cnt = q.wait_cnt - 16'h0001;
          end
        end
      end
      default: begin
        n.mode = smc_pkg::ST_NORMAL;
      end
    endcase
    n.awready = ~n.aw_have & ~n.bvalid;
    n.wready = ~n.w_have & ~n.bvalid;
    n.arready = ~n.rvalid;
    // Clock controls follow the next mode
    n.clk_out.cpu_clk_en = 1'b1;
    n.clk_out.periph_clk_en = 1'b1;
    n.clk_out.main_osc_en = 1'b1;
    n.clk_out.pll_en = n.clock_control[smc_pkg::CC_PLL_RUN];
    n.clk_out.flash_en = 1'b1;
    n.clk_out.sub_osc_en = 1'b1;
    n.clk_out.low_voltage = 1'b0;
    n.clk_out.sys_clk_sel = n.use_internal ? smc_pkg::SRC_INT : smc_pkg::SRC_MAIN;
    case (n.mode)
      smc_pkg::ST_HALT: begin
        n.clk_out.cpu_clk_en = 1'b0;
        if (n.clock_control[smc_pkg::CC_SUB_RUN]) begin
          n.clk_out.sys_clk_sel = smc_pkg::SRC_SUB;
        end
      end
      smc_pkg::ST_LIGHT_IDLE_STATE: begin
        n.clk_out.cpu_clk_en = 1'b0;
        n.clk_out.periph_clk_en = 1'b0;
      end
      smc_pkg::ST_DEEP_IDLE_STATE: begin
        n.clk_out.cpu_clk_en = 1'b0;
        n.clk_out.periph_clk_en = 1'b0;
        n.clk_out.flash_en = 1'b0;
        n.clk_out.pll_en = 1'b0;
      end
      smc_pkg::ST_STOP: begin
        n.clk_out.cpu_clk_en = 1'b0;
        n.clk_out.periph_clk_en = 1'b0;
        n.clk_out.main_osc_en = 1'b0;
        n.clk_out.pll_en = 1'b0;
        n.clk_out.flash_en = 1'b0;
        n.clk_out.low_voltage = n.clock_control[smc_pkg::CC_LV_STOP];
      end
      smc_pkg::ST_SUB, smc_pkg::ST_SUBIDLE, smc_pkg::ST_SUBWAIT: begin
        n.clk_out.sys_clk_sel = smc_pkg::SRC_SUB;
        n.clk_out.low_voltage = n.clock_control[smc_pkg::CC_LV_SUB];
        n.clk_out.main_osc_en = ~n.clock_control[smc_pkg::CC_LV_SUB];
        n.clk_out.pll_en = n.clock_control[smc_pkg::CC_PLL_RUN] & ~n.clock_control[smc_pkg::CC_LV_SUB];
        if (n.mode != smc_pkg::ST_SUB) begin
          n.clk_out.cpu_clk_en = 1'b0;
          n.clk_out.periph_clk_en = 1'b0;
        end
      end
      smc_pkg::ST_OSCWAIT: begin
        n.clk_out.cpu_clk_en = 1'b0;
        n.clk_out.periph_clk_en = 1'b0;
      end
      default: begin
        n.clk_out.cpu_clk_en = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.mode <= smc_pkg::ST_NORMAL;
      q.power_save_control <= smc_pkg::PSC_RESET;
      q.standby_kind_select <= smc_pkg::KIND_RESET;
      q.clock_control <= smc_pkg::CLOCK_RESET;
      q.clk_out <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0};
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign cpu_int_defer = q.int_defer;
  assign clk_ctrl = q.clk_out;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  AST_HALT_CPU_ONLY: assert property ((q.mode == smc_pkg::ST_HALT) |-> (!clk_ctrl.cpu_clk_en && clk_ctrl.periph_clk_en))
    else $error("Pause state clock gating wrong");
  AST_LIGHT_IDLE_STATE_KEEP: assert property ((q.mode == smc_pkg::ST_LIGHT_IDLE_STATE) |-> (clk_ctrl.main_osc_en && clk_ctrl.flash_en && !clk_ctrl.periph_clk_en))
    else $error("Light idle clocks wrong");
  AST_DEEP_IDLE_STATE_OSC: assert property ((q.mode == smc_pkg::ST_DEEP_IDLE_STATE) |-> (clk_ctrl.main_osc_en && !clk_ctrl.flash_en))
    else $error("Deep idle clocks wrong");
  AST_DEEP_IDLE_STATE_PLL: assert property ($rose(q.mode == smc_pkg::ST_DEEP_IDLE_STATE) |-> !clk_ctrl.pll_en)
    else $error("PLL not stopped in deep idle");
  AST_PLL_HOLD: assert property ((q.mode == smc_pkg::ST_NORMAL) ##1 (q.mode == smc_pkg::ST_LIGHT_IDLE_STATE) |-> clk_ctrl.pll_en == $past(clk_ctrl.pll_en))
    else $error("PLL changed entering light idle");
  AST_STOP_SUB_ONLY: assert property ((q.mode == smc_pkg::ST_STOP) |-> (clk_ctrl.sub_osc_en && !clk_ctrl.main_osc_en && !clk_ctrl.pll_en))
    else $error("STOP clocks wrong");
  AST_WDT_INTERNAL: assert property ((q.mode == smc_pkg::ST_OSCWAIT && watchdog_overflow_signal) |=> (clk_ctrl.sys_clk_sel == smc_pkg::SRC_INT))
    else $error("Internal clock not chosen");
  AST_UNPROTECTED: assert property ((psc_attempt && !q.protect_armed && q.mode == smc_pkg::ST_NORMAL) |=> $stable(q.power_save_control))
    else $error("Unprotected write took effect");
  AST_WDT_MASKED: assert property ((q.mode == smc_pkg::ST_LIGHT_IDLE_STATE && q.power_save_control[smc_pkg::WDT_DIS_BIT] && !maskable_irq && !nmi_edge) |=> (q.mode == smc_pkg::ST_LIGHT_IDLE_STATE))
    else $error("Disabled watchdog released standby");
  AST_STAY_NORMAL: assert property ((q.mode == smc_pkg::ST_NORMAL && !standby_request_bit && !halt_req && !q.clock_control[smc_pkg::CC_SUB_RUN]) |=> (q.mode == smc_pkg::ST_NORMAL))
    else $error("Left normal without request");
  AST_DEFER: assert property (psc_attempt |=> cpu_int_defer [*1] ##0 (q.mode != 9'h000))
    else $error("Interrupts not deferred");
endmodule : smc_standby_ctrl

// ### verification/smc_wake_model.sv
// Model of the CPU strobes and the wake sources around the controller.
// Assumes bench requests arrive as one-cycle pulses on clk.
`timescale 1ns/10ps
module smc_wake_model (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Bench requests
  input wire logic [2:0] fire,
  input wire logic halt_go,
  input wire logic step,
  // Toward the controller
  output logic halt_req,
  output logic instr_done,
  output logic maskable_irq,
  output logic nmi_pin,
  output logic watchdog_overflow_signal
);
  logic [3:0] cnt [3];

  // Sources stay high eight cycles, long enough for the pin synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      halt_req <= 1'b0;
      instr_done <= 1'b0;
      cnt <= '{default: 4'h0};
    end else begin
      halt_req <= halt_go;
      instr_done <= step;
      for (int i = 0; i < 3; i++) begin
        if (fire[i]) cnt[i] <= 4'h8;
        else if (cnt[i] != 4'h0) cnt[i] <= cnt[i] - 4'h1;
      end
    end
  end

  assign maskable_irq = cnt[0] != 4'h0;
  assign nmi_pin = cnt[1] != 4'h0;
  assign watchdog_overflow_signal = cnt[2] != 4'h0;
endmodule : smc_wake_model

// ### verification/standby_mode_control_test.sv
// Self-checking bench of the standby controller.
// Assumes smc_pkg, the controller and the wake model are compiled first.
`timescale 1ns/10ps
module standby_mode_control_test;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hf;
  logic [4:0] rq = '0;
  logic [2:0] sdiv = 3'h0;
  logic subclk;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rv;
  logic halt_req, instr_done, defer, irq, nmi, wdt;
  logic [7:0] db;
  smc_pkg::smc_clk_type cc;
  int n_mismatch = 0;
  int compares = 0;
  localparam logic [31:0] A_PROT = {smc_pkg::PROTECT_IDX, 2'b00};
  localparam logic [31:0] A_KIND = {smc_pkg::KIND_IDX, 2'b00};
  localparam logic [31:0] A_PSC = {smc_pkg::PSC_IDX, 2'b00};
  localparam logic [31:0] A_STAT = {smc_pkg::STATUS_IDX, 2'b00};
  localparam logic [31:0] A_CLK = {smc_pkg::CLOCK_IDX, 2'b00};

  always #25 clk = ~clk;

  // Subclock oscillator stand-in, eight system clocks a period
  always @(posedge clk) begin
    sdiv <= sdiv + 3'h1;
  end
  assign subclk = sdiv[2];

  smc_standby_ctrl u_dut (
    .clk(clk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .halt_req(halt_req), .instr_done(instr_done), .cpu_int_defer(defer),
    .watchdog_overflow_signal(wdt), .maskable_irq(irq), .nmi_pin(nmi),
    .subclk_pin(subclk), .clk_ctrl(cc)
  );

  smc_wake_model u_wake (
    .clk(clk), .arst_n(arst_n), .fire(rq[2:0]), .halt_go(rq[3]), .step(rq[4]),
    .halt_req(halt_req), .instr_done(instr_done), .maskable_irq(irq),
    .nmi_pin(nmi), .watchdog_overflow_signal(wdt)
  );

  task finish_test;
    if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, s, e);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [31:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  task pw(input logic [31:0] a, input logic [31:0] d);
    wr(A_PROT, {24'h0, smc_pkg::PROTECT_KEY});
    wr(a, d);
  endtask : pw

  // One-cycle request to the wake model
  task req(input logic [4:0] m);
    @(posedge clk);
    rq <= m;
    @(posedge clk);
    rq <= '0;
    #1;
  endtask : req

  task wait_cpu;
    int t;
    t = 0;
    while (cc.cpu_clk_en !== 1'b1 && t < 6000) begin
      tick(1);
      t++;
    end
  endtask : wait_cpu

  task enter(input logic [1:0] k, input logic [7:0] dis);
    wr(A_KIND, {30'h0, k});
    pw(A_PSC, {24'h0, dis | 8'h02});
    tick(2);
  endtask : enter

  function logic [8:0] exp_mode(input logic [1:0] k);
    if (k[0]) return smc_pkg::ST_STOP;
    return k[1] ? smc_pkg::ST_DEEP_IDLE_STATE : smc_pkg::ST_LIGHT_IDLE_STATE;
  endfunction : exp_mode

  initial begin
    #(40000 * 50);
    n_mismatch++;
    finish_test;
  end

  initial begin
    void'($urandom(97));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rd(A_PSC);
    chk(rv, 32'h0);
    db = 8'($urandom) & 8'h70;
    wr(A_PSC, {24'h0, db | 8'h02});
    tick(1);
    chk(defer, 1'b1);
    req(5'h10);
    tick(2);
    chk(defer, 1'b0);
    rd(A_PSC);
    chk(rv, 32'h0);
    pw(A_PSC, {24'h0, db});
    rd(A_PSC);
    chk(rv, {24'h0, db});
    chk(cc.cpu_clk_en, 1'b1);
    pw(A_PSC, 32'h0);
    rd(32'h10);
    chk(rs, smc_pkg::RESP_SLVERR);
    // Every standby kind, wake bits in the same write ignored
    for (int k = 0; k < 4; k++) begin
      enter(2'(k), 8'($urandom) & 8'h70);
      rd(A_STAT);
      chk(rv[8:0], exp_mode(2'(k)));
      chk({cc.cpu_clk_en, cc.main_osc_en, cc.pll_en, cc.flash_en}, {1'b0, !k[0], k == 0, k == 0});
      if (k[0]) chk(cc.sub_osc_en, 1'b1);
      req(5'h01);
      wait_cpu;
      rd(A_PSC);
      chk(rv, 32'h0);
    end
    // Disabled source ignored, another one wakes
    for (int s = 0; s < 3; s++) begin
      pw(A_PSC, 32'h10 << s);
      enter(2'h0, 8'h10 << s);
      req(5'h01 << s);
      tick(12);
      chk(cc.cpu_clk_en, 1'b0);
      req(5'h01 << ((s + 1) % 3));
      wait_cpu;
      chk(cc.cpu_clk_en, 1'b1);
      pw(A_PSC, 32'h0);
    end
    req(5'h08);
    tick(2);
    chk({cc.cpu_clk_en, cc.periph_clk_en}, 2'b01);
    req(5'h01);
    wait_cpu;
    // Subclock run, slow-clock idle and its subclock-counted wake
    wr(A_CLK, 32'h01);
    tick(2);
    rd(A_STAT);
    chk(rv[8:0], smc_pkg::ST_SUB);
    chk(cc.sys_clk_sel, smc_pkg::SRC_SUB);
    enter(2'h0, 8'h00);
    rd(A_STAT);
    chk(rv[8:0], smc_pkg::ST_SUBIDLE);
    chk(cc.cpu_clk_en, 1'b0);
    req(5'h01);
    wait_cpu;
    rd(A_STAT);
    chk(rv[8:0], smc_pkg::ST_SUB);
    wr(A_CLK, 32'h08);
    tick(2);
    rd(A_STAT);
    chk(rv[8:0], smc_pkg::ST_NORMAL);
    // Watchdog during the oscillation wait
    enter(2'h1, 8'h00);
    req(5'h01);
    tick(20);
    req(5'h04);
    wait_cpu;
    chk(cc.sys_clk_sel, smc_pkg::SRC_INT);
    finish_test;
  end
endmodule : standby_mode_control_test
